// ===== rtl/flash_host_sequencer.sv
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module flash_host_sequencer (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          ce_i,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [7:0]                    wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   output logic      [flash_host_pkg::AW-1:0] flash_addr_o,
   output logic      [flash_host_pkg::DW-1:0] flash_dq_o,
   output logic                               flash_dq_oe_n_o,
   input  wire logic [flash_host_pkg::DW-1:0] flash_dq_i,
   output logic                               flash_ce_n_o,
   output logic                               flash_we_n_o,
   output logic                               flash_oe_n_o,
   output logic                               flash_reset_n_o,
   output logic                               write_protect_accelerate_o,
   input  wire logic                          ready_busy_i
);
   import flash_host_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_GAP}
      phase_t;

   typedef struct packed {
      phase_t          ph;
      op_t             op;
      logic [2:0]      idx;
      logic [2:0]      cnt;
      logic [AW-1:0]   addr;
      logic [DW-1:0]   wdata;
      logic [DW-1:0]   rdata;
      logic [AW-1:0]   pin_addr;
      logic [DW-1:0]   pin_dq;
      logic            dq_oe_n;
      logic            ce_n;
      logic            we_n;
      logic            oe_n;
      logic            hw_rst;
      logic            accel;
      logic [9:0]      win_cnt;
      logic            win_open;
      logic            refused;
      logic            ack;
      logic [31:0]     dat;
      logic            rb_s1;
      logic            rb_s2;
      logic [DW-1:0]   dq_s1;
      logic [DW-1:0]   dq_s2;
   } state_t;

   state_t s;
   state_t next_s;

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // one bus cycle of a sequence: {last, is_read, address, data}
   function automatic logic [AW+DW+1:0] step(input op_t op,
                                             input logic [2:0] idx,
                                             input logic [AW-1:0] a,
                                             input logic [DW-1:0] d);
      logic [AW-1:0] ba;
      logic [AW-1:0] ad;
      logic [DW-1:0] dt;
      logic          last;
      logic          rd;
      ba   = {a[AW-1:11], BANK_LOW};
      ad   = UNLOCK_A1;
      dt   = {8'h00, CD_UNLOCK1};
      last = 1'b0;
      rd   = 1'b0;
      if (idx == 3'd1 || idx == 3'd4) begin
         ad = UNLOCK_A2;
         dt = {8'h00, CD_UNLOCK2};
      end
      case (op)
         OP_RESET: begin
            last = 1'b1;
            dt   = {8'h00, CD_RESET};
         end
         OP_READ: begin
            last = 1'b1;
            rd   = 1'b1;
            ad   = a;
         end
         OP_SUSPEND: begin
            last = 1'b1;
            ad   = ba;
            dt   = {8'h00, CD_SUSPEND};
         end
         OP_SECT_ADD: begin
            last = 1'b1;
            ad   = a;
            dt   = {8'h00, CD_SECTOR};
         end
         OP_BYP_PROG: begin
            last = (idx == 3'd1);
            ad   = (idx == 3'd1) ? a : UNLOCK_A1;
            dt   = (idx == 3'd1) ? d : {8'h00, CD_PROGRAM};
         end
         OP_BYP_RESET: begin
            last = (idx == 3'd1);
            ad   = UNLOCK_A1;
            dt   = {8'h00, (idx == 3'd1) ? CD_ZERO : CD_AUTOSEL};
         end
         default: begin
            if (idx == 3'd2) begin
               last = (op == OP_AUTOSEL || op == OP_BYP_ENTER ||
                       op == OP_SEC_ENTER);
               ad   = (op == OP_AUTOSEL) ? ba : UNLOCK_A1;
               case (op)
                  OP_AUTOSEL:   dt = {8'h00, CD_AUTOSEL};
                  OP_PROGRAM:   dt = {8'h00, CD_PROGRAM};
                  OP_BYP_ENTER: dt = {8'h00, CD_BYPASS};
                  OP_SEC_ENTER: dt = {8'h00, CD_SECURE};
                  OP_SEC_EXIT:  dt = {8'h00, CD_AUTOSEL};
                  default:      dt = {8'h00, CD_ERASE};
               endcase
            end else if (idx == 3'd3) begin
               last = (op != OP_CHIP_ERASE && op != OP_SECT_ERASE);
               if (op == OP_PROGRAM) begin
                  ad = a;
                  dt = d;
               end else if (op == OP_SEC_EXIT) begin
                  dt = {8'h00, CD_ZERO};
               end
            end else if (idx == 3'd5) begin
               last = 1'b1;
               ad   = (op == OP_SECT_ERASE) ? a : UNLOCK_A1;
               dt   = {8'h00, (op == OP_SECT_ERASE) ? CD_SECTOR : CD_CHIP};
            end
         end
      endcase
      return {last, rd, ad, dt};
   endfunction : step

   logic [AW+DW+1:0] cur;
   logic             wb_req;
   logic             start;
   logic             allowed;
   op_t              req_op;

   assign cur    = step(s.op, s.idx, s.addr, s.wdata);
   assign wb_req = wb_cyc_i && wb_stb_i && !s.ack;
   assign start  = wb_req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0];
   assign req_op = (wb_dat_i[3:0] < 4'(OP_NONE)) ? op_t'(wb_dat_i[3:0])
                                                 : OP_NONE;

   // --------------------------------------------------------------
   // command acceptance
   // --------------------------------------------------------------
   // outside the erase window a busy flash takes only reset, reads and suspend; others refused
   always_comb begin
      allowed = (s.ph == S_IDLE) && (req_op != OP_NONE);
      if (!s.rb_s2 && !s.win_open && req_op != OP_READ &&
          req_op != OP_RESET && req_op != OP_SUSPEND) begin
         allowed = 1'b0;
      end
      if (req_op == OP_AUTOSEL && !s.rb_s2) begin
         allowed = 1'b0;
      end
      // extra sectors only inside the window
      if (req_op == OP_SECT_ADD && !s.win_open) begin
         allowed = 1'b0;
      end
   end

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      next_s       = s;
      next_s.rb_s1 = ready_busy_i;
      next_s.rb_s2 = s.rb_s1;
      next_s.dq_s1 = flash_dq_i;
      next_s.dq_s2 = s.dq_s1;
      next_s.ack   = wb_req;
      next_s.dat   = 32'h0000_0000;
      // wishbone registers
      if (wb_req && wb_we_i) begin
         if (wb_adr_i == REG_ADDR) begin
            next_s.addr = AW'(merge(32'(s.addr), wb_dat_i, wb_sel_i));
         end else if (wb_adr_i == REG_WDATA) begin
            next_s.wdata = DW'(merge(32'(s.wdata), wb_dat_i, wb_sel_i));
         end else if (wb_adr_i == REG_PINCTRL && wb_sel_i[0]) begin
            next_s.hw_rst = wb_dat_i[PC_HWRST];
            // accelerate pin drives bypass mode in the flash
            next_s.accel  = wb_dat_i[PC_ACCEL];
         end
      end else if (wb_req) begin
         if (wb_adr_i == REG_ADDR) begin
            next_s.dat = 32'(s.addr);
         end else if (wb_adr_i == REG_WDATA) begin
            next_s.dat = 32'(s.wdata);
         end else if (wb_adr_i == REG_STATUS) begin
            next_s.dat[ST_BUSY]    = (s.ph != S_IDLE);
            next_s.dat[ST_READY]   = s.rb_s2;
            next_s.dat[ST_WINDOW]  = s.win_open;
            next_s.dat[ST_REFUSED] = s.refused;
         end else if (wb_adr_i == REG_PINCTRL) begin
            next_s.dat[PC_HWRST] = s.hw_rst;
            next_s.dat[PC_ACCEL] = s.accel;
         end else if (wb_adr_i == REG_RDATA) begin
            next_s.dat = 32'(s.rdata);
         end
      end
      if (s.win_open) begin
         next_s.win_cnt  = s.win_cnt - 10'd1;
         next_s.win_open = (s.win_cnt != 10'd1);
      end
      if (start) begin
         next_s.refused = !allowed;
         if (allowed) begin
            next_s.op  = req_op;
            next_s.idx = 3'd0;
            next_s.ph  = S_SETUP;
            // any command but sector add or suspend cancels the queued erase
            if (req_op != OP_SECT_ADD && req_op != OP_SUSPEND) begin
               next_s.win_open = 1'b0;
            end
         end
      end
      // bus cycle phases
      case (s.ph)
         S_SETUP: begin
            // address settles before the strobe falls
            next_s.ce_n     = 1'b0;
            next_s.pin_addr = cur[AW+DW-1:DW];
            next_s.pin_dq   = cur[DW-1:0];
            next_s.dq_oe_n  = cur[AW+DW];
            next_s.oe_n     = !cur[AW+DW];
            next_s.cnt      = cur[AW+DW] ? 3'(ACC_CYC) : 3'(WP_CYC);
            next_s.ph       = S_STROBE;
         end
         S_STROBE: begin
            next_s.we_n = cur[AW+DW];
            next_s.cnt  = s.cnt - 3'd1;
            if (s.cnt == 3'd1) begin
               next_s.ph = S_HOLD;
            end
         end
         S_HOLD: begin
            // data held while write strobe rises
            next_s.we_n = 1'b1;
            if (cur[AW+DW]) begin
               next_s.rdata = s.dq_s2;
            end
            // window starts at the final rising strobe
            if (cur[AW+DW+1] && (s.op == OP_SECT_ERASE ||
                                 s.op == OP_SECT_ADD)) begin
               next_s.win_open = 1'b1;
               next_s.win_cnt  = 10'(WIN_CYC);
            end
            next_s.ph = S_GAP;
         end
         S_GAP: begin
            next_s.ce_n    = 1'b1;
            next_s.oe_n    = 1'b1;
            next_s.dq_oe_n = 1'b1;
            next_s.idx     = s.idx + 3'd1;
            next_s.ph      = cur[AW+DW+1] ? S_IDLE : S_SETUP;
         end
         default: begin
         end
      endcase
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   // clock enable low freezes every bit, synchronisers included
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s         <= '0;
         s.ph      <= S_IDLE;
         s.op      <= OP_NONE;
         s.dq_oe_n <= 1'b1;
         s.ce_n    <= 1'b1;
         s.we_n    <= 1'b1;
         s.oe_n    <= 1'b1;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign wb_dat_o                   = s.dat;
   assign wb_ack_o                   = s.ack;
   assign flash_addr_o               = s.pin_addr;
   assign flash_dq_o                 = s.pin_dq;
   assign flash_dq_oe_n_o            = s.dq_oe_n;
   assign flash_ce_n_o               = s.ce_n;
   assign flash_we_n_o               = s.we_n;
   assign flash_oe_n_o               = s.oe_n;
   assign flash_reset_n_o            = !s.hw_rst;
   assign write_protect_accelerate_o = s.accel;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   property p_strobe_in_select;
      @(posedge clk_i) disable iff (rst_i)
      !s.we_n |-> !s.ce_n && !s.dq_oe_n && s.oe_n;
   endproperty
   a_strobe_in_select: assert property (p_strobe_in_select)
      else $error("write strobe outside select or without data drive");

   property p_reset_code;
      @(posedge clk_i) disable iff (rst_i || !ce_i)
      s.ph == S_SETUP && s.op == OP_RESET |=>
         s.pin_dq[7:0] == CD_RESET && s.dq_oe_n == 1'b0;
   endproperty
   a_reset_code: assert property (p_reset_code)
      else $error("reset cycle does not carry f0");

   property p_unlock_first;
      @(posedge clk_i) disable iff (rst_i || !ce_i)
      s.ph == S_SETUP && s.idx == 3'd0 && s.op == OP_PROGRAM |=>
         s.pin_addr == UNLOCK_A1 && s.pin_dq[7:0] == CD_UNLOCK1;
   endproperty
   a_unlock_first: assert property (p_unlock_first)
      else $error("first unlock cycle wrong");

   property p_program_len;
      @(posedge clk_i) disable iff (rst_i || !ce_i)
      s.ph == S_GAP && s.op == OP_PROGRAM && s.idx == 3'd3 |=>
         s.ph == S_IDLE;
   endproperty
   a_program_len: assert property (p_program_len)
      else $error("program sequence not four cycles");

   property p_bypass_len;
      @(posedge clk_i) disable iff (rst_i || !ce_i)
      s.ph == S_GAP && s.op == OP_BYP_PROG |=>
         (s.idx == 3'd1) == (s.ph == S_SETUP);
   endproperty
   a_bypass_len: assert property (p_bypass_len)
      else $error("bypass program not two cycles");

   property p_erase_len;
      @(posedge clk_i) disable iff (rst_i || !ce_i)
      s.ph == S_GAP && s.op == OP_CHIP_ERASE |=>
         (s.ph == S_IDLE) == ($past(s.idx) == 3'd5);
   endproperty
   a_erase_len: assert property (p_erase_len)
      else $error("chip erase not six cycles");

   property p_window_start;
      @(posedge clk_i) disable iff (rst_i || !ce_i)
      $rose(s.win_open) |-> s.win_cnt == 10'(WIN_CYC) && s.we_n;
   endproperty
   a_window_start: assert property (p_window_start)
      else $error("erase window not loaded at strobe rise");

   property p_autosel_refused;
      @(posedge clk_i) disable iff (rst_i || !ce_i)
      start && req_op == OP_AUTOSEL && !s.rb_s2 |=>
         s.refused && ($past(s.ph) != S_IDLE || s.ph == S_IDLE);
   endproperty
   a_autosel_refused: assert property (p_autosel_refused)
      else $error("autoselect issued while flash busy");

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i || !ce_i)
      s.ack |=> !s.ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");
endmodule : flash_host_sequencer
`default_nettype wire

// ===== shared/flash_host_pkg.sv
package flash_host_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses on the wishbone side)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_ADDR     = 8'h04;
   localparam logic [7:0] REG_WDATA    = 8'h08;
   localparam logic [7:0] REG_STATUS   = 8'h0c;
   localparam logic [7:0] REG_PINCTRL  = 8'h10;
   localparam logic [7:0] REG_RDATA    = 8'h14;
   // status and pin control field positions
   localparam int ST_BUSY    = 0;
   localparam int ST_READY   = 1;
   localparam int ST_WINDOW  = 2;
   localparam int ST_REFUSED = 3;
   localparam int PC_HWRST   = 0;
   localparam int PC_ACCEL   = 1;
   // ------------------------------------------------------------
   // widths and command codes
   // ------------------------------------------------------------
   localparam int AW = 21;
   localparam int DW = 16;
   localparam logic [AW-1:0] UNLOCK_A1 = 21'h000555;
   localparam logic [AW-1:0] UNLOCK_A2 = 21'h0002aa;
   localparam logic [10:0]   BANK_LOW  = 11'h555;
   localparam logic [7:0] CD_UNLOCK1 = 8'haa;
   localparam logic [7:0] CD_UNLOCK2 = 8'h55;
   localparam logic [7:0] CD_RESET   = 8'hf0;
   localparam logic [7:0] CD_AUTOSEL = 8'h90;
   localparam logic [7:0] CD_PROGRAM = 8'ha0;
   localparam logic [7:0] CD_BYPASS  = 8'h20;
   localparam logic [7:0] CD_ERASE   = 8'h80;
   localparam logic [7:0] CD_CHIP    = 8'h10;
   localparam logic [7:0] CD_SECTOR  = 8'h30;
   localparam logic [7:0] CD_SUSPEND = 8'hb0;
   localparam logic [7:0] CD_SECURE  = 8'h88;
   localparam logic [7:0] CD_ZERO    = 8'h00;
   // operations written to the control register
   typedef enum logic [3:0] {
      OP_RESET, OP_AUTOSEL, OP_READ, OP_PROGRAM, OP_BYP_ENTER,
      OP_BYP_PROG, OP_BYP_RESET, OP_CHIP_ERASE, OP_SECT_ERASE,
      OP_SECT_ADD, OP_SUSPEND, OP_SEC_ENTER, OP_SEC_EXIT, OP_NONE
   } op_t;
   // ------------------------------------------------------------
   // timing at 20 MHz
   // ------------------------------------------------------------
   localparam int CLK_NS       = 50;
   localparam int T_WP_NS      = 35;
   localparam int T_ACC_NS     = 90;
   localparam int T_WINDOW_US  = 50;
   localparam int WP_CYC  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + 2;
   localparam int WIN_CYC = (T_WINDOW_US * 1000) / CLK_NS;
endpackage : flash_host_pkg

// ===== tb/flash_device_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_device_model #(
   parameter logic [15:0] MFR_CODE = 16'h005a, // arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h7e3c, // arbitrary value
   parameter logic [8:0]  PROT_SEC = 9'h103,
   parameter int          OP_NS    = 5000,
   parameter int          WIN_NS   = 50000
) (
   input  wire logic [20:0] addr_i,
   input  wire logic [15:0] dq_i,
   input  wire logic        ce_n_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        reset_n_i,
   input  wire logic        accel_i,
   output logic      [15:0] dq_o,
   output logic             ready_busy_o
);
   // ----------------------------------------
   // state: mode 0 read, 1 autoselect, 2 bypass
   // ----------------------------------------
   logic [15:0] mem [logic [20:0]];
   logic [20:0] la;
   logic [1:0]  mode [2];
   logic        sec;
   logic [15:0] junk;
   int          step, byp;
   realtime     busy_to, win_to;

   function automatic logic [15:0] rd(input logic [20:0] a);
      if (sec) return 16'hc000 | 16'(a[3:0]);
      if (mode[a[20]] == 2'd1 && a[7:0] == 8'h00) return MFR_CODE;
      if (mode[a[20]] == 2'd1 && a[7:0] == 8'h01) return DEV_CODE;
      if (mode[a[20]] == 2'd1 && a[7:0] == 8'h02) return 16'(a[20:12] == PROT_SEC);
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction : rd

   task automatic erase(input logic [20:0] a, input logic all);
      logic [20:0] q[$];
      foreach (mem[k]) if (all || k[20:12] == a[20:12]) q.push_back(k);
      foreach (q[i]) mem.delete(q[i]);
      busy_to = $realtime + OP_NS + (all ? 0 : WIN_NS);
      win_to = all ? 0 : $realtime + WIN_NS;
   endtask : erase

   // bits only clear, busy until done
   task automatic prog(input logic [20:0] a, input logic [15:0] d);
      mem[a] = rd(a) & d;
      busy_to = $realtime + OP_NS;
   endtask : prog

   task automatic wr(input logic [20:0] a, input logic [15:0] d);
      logic u;
      u = (a[10:0] == 11'h555);
      if ($realtime < busy_to) begin
         // more sectors in the window, others but suspend cancel it
         if ($realtime < win_to && d[7:0] == 8'h30) erase(a, 1'b0);
         else if ($realtime < win_to && d[7:0] != 8'hb0) busy_to = 0;
         return;
      end
      // bypass takes only its program and reset
      if (mode[a[20]] == 2'd2) begin
         if (byp == 1) prog(a, d);
         // bypass reset ignores the address, so every bypassed bank leaves
         if (byp == 2 && d[7:0] == 8'h00) begin
            if (mode[0] == 2'd2) mode[0] = 2'd0;
            if (mode[1] == 2'd2) mode[1] = 2'd0;
         end
         byp = (byp == 0 && d[7:0] == 8'ha0) ? 1 : (d[7:0] == 8'h90) ? 2 : 0;
         return;
      end
      // reset ignores the address, not program data
      if (d[7:0] == 8'hf0 && step != 6) begin
         step = 0;
         mode[0] = 2'd0;
         mode[1] = 2'd0;
         return;
      end
      // cycle decode, bank held per mode
      case (step)
         0, 3: step = (u && d[7:0] == 8'haa) ? step + 1 : 0;
         1, 4: step = (a[10:0] == 11'h2aa && d[7:0] == 8'h55) ? step + 1 : 0;
         2: begin
            step = (u && d[7:0] == 8'h80) ? 3 : (u && d[7:0] == 8'ha0) ? 6 : 0;
            if (u && d[7:0] == 8'h90 && sec) step = 7;
            else if (u && d[7:0] == 8'h90) mode[a[20]] = 2'd1;
            if (u && d[7:0] == 8'h88) sec = 1'b1;
            if (u && d[7:0] == 8'h20) mode[a[20]] = 2'd2;
         end
         5: begin
            step = 0;
            if (d[7:0] == 8'h10 || d[7:0] == 8'h30) erase(a, d[7:0] == 8'h10);
         end
         6: begin
            step = 0;
            prog(a, d);
         end
         default: begin
            step = 0;
            sec = (d[7:0] == 8'h00) ? 1'b0 : sec;
         end
      endcase
   endtask : wr

   // address on falling strobe, data on rising
   always @(negedge we_n_i) la = addr_i;
   always @(posedge we_n_i) if (!ce_n_i && reset_n_i) wr(la, dq_i);
   always @(posedge accel_i) begin
      mode[0] = 2'd2;
      mode[1] = 2'd2;
   end
   always @(negedge reset_n_i) begin
      busy_to = 0;
      step = 0;
      mode[0] = 2'd0;
      mode[1] = 2'd0;
   end
   // ready pin; a released bus moves so stale data cannot pass
   initial begin
      sec = 1'b0;
      step = 0;
      byp = 0;
      busy_to = 0;
      win_to = 0;
      junk = 16'h0000;
      forever begin
         ready_busy_o = ($realtime >= busy_to);
         dq_o = (!ce_n_i && !oe_n_i) ? rd(addr_i) : junk;
         junk = junk + 16'h3b1d;
         #5;
      end
   end
endmodule : flash_device_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   import flash_host_pkg::*;
   localparam logic [15:0] MFR = 16'h005a; // arbitrary value
   localparam logic [15:0] DEV = 16'h7e3c; // arbitrary value
   logic          clk_i, rst_i, ce_i, cyc, stb, we, ack, doe_n;
   logic          ce_n, we_n, oe_n, reset_n, accel, ready;
   logic [7:0]    adr;
   logic [3:0]    sel;
   logic [31:0]   dat, rdat, r;
   logic [AW-1:0] fa, a;
   logic [DW-1:0] fdo, mdq, bus, d;
   integer        seed;
   int            errors, check_count, i;
   logic [15:0]   shadow [logic [20:0]];

   // the dq wire follows whoever enables it
   assign bus = !doe_n ? fdo : mdq;
   flash_host_sequencer flash_host_sequencer_inst (.clk_i(clk_i),
      .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .flash_addr_o(fa),
      .flash_dq_o(fdo), .flash_dq_oe_n_o(doe_n), .flash_dq_i(bus),
      .flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n),
      .flash_reset_n_o(reset_n), .write_protect_accelerate_o(accel),
      .ready_busy_i(ready));
   flash_device_model #(.MFR_CODE(MFR), .DEV_CODE(DEV))
   flash_device_model_inst (.addr_i(fa), .dq_i(bus), .ce_n_i(ce_n),
      .we_n_i(we_n), .oe_n_i(oe_n), .reset_n_i(reset_n),
      .accel_i(accel), .dq_o(mdq), .ready_busy_o(ready));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] exp_rd(input logic [20:0] x);
      return shadow.exists(x) ? shadow[x] : 16'hffff;
   endfunction : exp_rd

   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : check

   // request stands until ack is sampled at an edge
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, ad, dt, 4'hf};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      errors += (n >= 50);
      {cyc, stb} <= 2'b00;
   endtask : wb

   task automatic wait_st(input int b, input logic v);
      int n;
      n = 0;
      do begin
         wb(1'b0, REG_STATUS, 32'h0, r);
         n++;
      end while (r[b] !== v && n < 3000);
      errors += (n >= 3000);
   endtask : wait_st

   task automatic op(input op_t o, input logic [20:0] x, input logic [15:0] y);
      wb(1'b1, REG_ADDR, 32'(x), r);
      wb(1'b1, REG_WDATA, 32'(y), r);
      wb(1'b1, REG_CTRL, 32'(o), r);
      wait_st(ST_BUSY, 1'b0);
   endtask : op

   task automatic pgm(input op_t o, input logic [20:0] x, input logic [15:0] y);
      op(o, x, y);
      wait_st(ST_READY, 1'b1);
      shadow[x] = exp_rd(x) & y;
   endtask : pgm

   task automatic fread(input logic [20:0] x, output logic [31:0] q);
      op(OP_READ, x, 16'h0);
      wb(1'b0, REG_RDATA, 32'h0, q);
   endtask : fread

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // bound well above the longest erase wait
   initial begin
      repeat (60000) @(posedge clk_i);
      errors++;
      report_and_stop();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {rst_i, ce_i, cyc, stb, we, adr, sel, dat} = {2'b11, 47'h0};
      {errors, check_count, seed} = {64'h0, 32'h3417aa82};
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(1'b0, REG_STATUS, 32'h0, r);
      check("status", r, 32'h2);
      wb(1'b0, 8'h1c, 32'h0, r);
      check("unmapped", r, 32'h0);
      wb(1'b1, REG_PINCTRL, 32'h2, r);
      wb(1'b0, REG_PINCTRL, 32'h0, r);
      check("pinctrl", r, 32'h2);
      pgm(OP_BYP_PROG, 21'h000100, 16'h1234);
      wb(1'b1, REG_PINCTRL, 32'h0, r);
      op(OP_BYP_RESET, 21'h0, 16'h0);
      fread(21'h000100, r);
      check("accel program", r, 32'(exp_rd(21'h000100)));
      $display("test pins done");
      op(OP_AUTOSEL, 21'h100000, 16'h0);
      fread(21'h100000, r);
      check("maker id", r, 32'(MFR));
      fread(21'h100001, r);
      check("device id", r, 32'(DEV));
      fread(21'h103002, r);
      check("protected", r, 32'h1);
      fread(21'h105002, r);
      check("unprotected", r, 32'h0);
      fread(21'h000100, r);
      check("other bank", r, 32'(exp_rd(21'h000100)));
      op(OP_RESET, 21'($random(seed)), 16'h0);
      fread(21'h100000, r);
      check("after reset", r, 32'(exp_rd(21'h100000)));
      $display("test autoselect done");
      for (i = 0; i < 8; i++) begin
         if (i < 5) a = 21'($random(seed));
         d = (i < 6) ? 16'($random(seed)) : 16'h0;
         if (i > 5) a = {9'h0a0 + 9'(i), 12'h010};
         pgm(i < 6 ? OP_PROGRAM : OP_BYP_PROG, a, d);
         fread(a, r);
         check("program", r, 32'(exp_rd(a)));
         if (i == 5) op(OP_BYP_ENTER, 21'h0, 16'h0);
      end
      op(OP_BYP_RESET, 21'h0, 16'h0);
      $display("test program done");
      op(OP_SEC_ENTER, 21'h0, 16'h0);
      fread(21'h000003, r);
      check("serial", r, 32'h0000c003);
      op(OP_SEC_EXIT, 21'h0, 16'h0);
      fread(21'h000100, r);
      check("normal", r, 32'(exp_rd(21'h000100)));
      op(OP_SECT_ERASE, 21'h0a6000, 16'h0);
      op(OP_SECT_ADD, 21'h0a7000, 16'h0);
      wb(1'b0, REG_STATUS, 32'h0, r);
      check("window", 32'(r[ST_WINDOW]), 32'h1);
      wait_st(ST_READY, 1'b1);
      for (i = 6; i < 8; i++) begin
         shadow.delete({9'h0a0 + 9'(i), 12'h010});
         fread({9'h0a0 + 9'(i), 12'h010}, r);
         check("erased", r, 32'hffff);
      end
      $display("test erase done");
      op(OP_CHIP_ERASE, 21'h0, 16'h0);
      wb(1'b1, REG_CTRL, 32'(OP_PROGRAM), r);
      wb(1'b0, REG_STATUS, 32'h0, r);
      check("refused", 32'(r[ST_REFUSED]), 32'h1);
      wb(1'b1, REG_CTRL, 32'(OP_AUTOSEL), r);
      wb(1'b0, REG_STATUS, 32'h0, r);
      check("autoselect busy", 32'(r[ST_REFUSED]), 32'h1);
      op(OP_SUSPEND, 21'h0, 16'h0);
      wb(1'b0, REG_STATUS, 32'h0, r);
      check("suspend taken", 32'(r[ST_REFUSED]), 32'h0);
      wb(1'b1, REG_PINCTRL, 32'h1, r);
      check("hw reset", 32'(reset_n), 32'h0);
      wb(1'b1, REG_PINCTRL, 32'h0, r);
      wait_st(ST_READY, 1'b1);
      shadow.delete();
      fread(21'h000100, r);
      check("chip erased", r, 32'hffff);
      $display("test chip done");
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
